// file: iab_defs.svh
// Constants of the address/baud and buffer register block
// Behaviour
// (R01) Master mode drives an SCL period of four times (divider value + 1) clocks.
// (R02) The upper 10-bit address byte must carry 11110 on top; hardware checks it.
// (R03) Upper 10-bit byte bits 2..1 match divider bits 2..1; bit 0 is ignored.
// (R04) Lower 10-bit byte matches all eight divider bits.
// (R05) In 7-bit slave mode divider bits 7..1 form the address, bit 0 ignored.
// (R06) Buffer is read/write, undefined at power-up and kept over every reset.
// (R07) With the dedicated pins the threshold select setting is disregarded.
// (R08) Software never programs divider values 0, 1 or 2 in this mode.
// (R09) An address bit is compared only where its mask bit is one.
`ifndef IAB_DEFS_SVH
`define IAB_DEFS_SVH
`define IAB_OFF_ADDR_BAUD 8'h00
`define IAB_OFF_BUFFER 8'h04
`define IAB_OFF_STATUS 8'h08
`define IAB_OFF_CON1 8'h0c
`define IAB_OFF_CON2 8'h10
`define IAB_OFF_CON3 8'h14
`define IAB_OFF_MASK 8'h18
`define IAB_RST_ADDR_BAUD 8'h00
`define IAB_RST_CON 8'h00
`define IAB_RST_MASK 8'hff
`define IAB_CON1_EN 5
`define IAB_MODE_MASTER 4'h8
`define IAB_MODE_SLV7 3'h6
`define IAB_MODE_SLV10 3'h7
`define IAB_HI_PATTERN 5'h1e
`define IAB_ST_BF 0
`define IAB_ST_UA 1
`define IAB_ST_DA 5
`define IAB_SCL_QUARTERS 4
`endif

// file: iab_pkg.sv
// Types of the address/baud and buffer register block
package iab_pkg;
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_ADDR = 3'b001,
        L_ADDR2 = 3'b010,
        L_DATA = 3'b011,
        L_SKIP = 3'b100
    } iab_lstate_t;
    typedef enum logic [1:0] {
        EV_A7 = 2'b00,
        EV_HI = 2'b01,
        EV_LO = 2'b10,
        EV_DATA = 2'b11
    } iab_ev_t;
    typedef struct packed {
        logic en;
        logic [3:0] mode;
        logic [7:0] add;
        logic [7:0] msk;
    } iab_cfg_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } iab_dphase_t;
endpackage

// file: iab_top.sv
// Address/baud register, buffer and address matcher with AHB-Lite access
`timescale 1ns/1ps
`include "iab_defs.svh"
module iab_top
    import iab_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic clk_link,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic dedicated_pins,
    input wire logic input_threshold_select,
    output logic pin_threshold_sel
);
    logic [7:0] address_baud_reg;
    logic [7:0] serial_buffer_reg;
    logic [7:0] port_control_one_reg;
    logic [7:0] port_control_two_reg;
    logic [7:0] port_control_three_reg;
    logic [7:0] address_mask_reg;
    logic st_bf;
    logic st_ua;
    logic st_da;
    iab_dphase_t dp;
    logic ap_valid;
    logic wr_add;
    logic wr_buf;
    logic rd_buf;
    logic [2:0] ev_sy;
    logic ev_new;
    logic [7:0] ev_byte;
    iab_ev_t ev_kind;
    logic ev_tgl;
    logic master;
    logic [8:0] scl_cnt;
    logic [1:0] ded_sy;
    logic [1:0] thr_sy;

    // Bus decode; hsize is unused as only whole words are served
    assign ap_valid = hsel & htrans[1] & hready;
    assign wr_add = dp.wr && dp.addr == `IAB_OFF_ADDR_BAUD;
    assign wr_buf = dp.wr && dp.addr == `IAB_OFF_BUFFER;
    assign rd_buf = ap_valid && !hwrite && haddr[7:0] == `IAB_OFF_BUFFER;
    assign ev_new = ev_sy[1] ^ ev_sy[2];
    assign master = port_control_one_reg[`IAB_CON1_EN]
        && port_control_one_reg[3:0] == `IAB_MODE_MASTER;

    // Read mux, forwarding a write still in its data phase
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `IAB_OFF_ADDR_BAUD: v = address_baud_reg;
            `IAB_OFF_BUFFER: v = serial_buffer_reg;
            `IAB_OFF_STATUS: v = {2'h0, st_da, 3'h0, st_ua, st_bf};
            `IAB_OFF_CON1: v = port_control_one_reg;
            `IAB_OFF_CON2: v = port_control_two_reg;
            `IAB_OFF_CON3: v = port_control_three_reg;
            `IAB_OFF_MASK: v = address_mask_reg;
            default: v = 8'h00;
        endcase
        if (dp.wr && dp.addr == a && a != `IAB_OFF_STATUS)
        begin
            v = hwdata[7:0];
        end
        return v;
    endfunction

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            dp.wr <= ap_valid & hwrite;
            if (ap_valid)
            begin
                dp.addr <= haddr[7:0];
            end
            if (ap_valid && !hwrite)
            begin
                hrdata <= {24'h00_0000, rd_val(haddr[7:0])};
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            address_baud_reg <= `IAB_RST_ADDR_BAUD;
            port_control_one_reg <= `IAB_RST_CON;
            port_control_two_reg <= `IAB_RST_CON;
            port_control_three_reg <= `IAB_RST_CON;
            address_mask_reg <= `IAB_RST_MASK;
        end
        else if (dp.wr)
        begin
            case (dp.addr)
                `IAB_OFF_ADDR_BAUD: address_baud_reg <= hwdata[7:0];
                `IAB_OFF_CON1: port_control_one_reg <= hwdata[7:0];
                `IAB_OFF_CON2: port_control_two_reg <= hwdata[7:0];
                `IAB_OFF_CON3: port_control_three_reg <= hwdata[7:0];
                `IAB_OFF_MASK: address_mask_reg <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Buffer has no reset so its content survives every reset
    always_ff @(posedge clk_sys)
    begin
        if (wr_buf)
        begin
            serial_buffer_reg <= hwdata[7:0]; // R06
        end
        else if (ev_new)
        begin
            serial_buffer_reg <= ev_byte;
        end
    end

    // Status flags; a new byte beats a clearing access
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_sy <= 3'h0;
            st_bf <= 1'b0;
            st_ua <= 1'b0;
            st_da <= 1'b0;
        end
        else
        begin
            ev_sy <= {ev_sy[1:0], ev_tgl};
            if (ev_new)
            begin
                st_bf <= 1'b1;
                st_da <= ev_kind == EV_DATA;
            end
            else if (rd_buf)
            begin
                st_bf <= 1'b0;
            end
            if (ev_new && ev_kind == EV_HI)
            begin
                st_ua <= 1'b1;
            end
            else if (wr_add)
            begin
                st_ua <= 1'b0;
            end
        end
    end

    // SCL divider: half period is 2*(divider+1) clocks
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_cnt <= 9'h000;
            scl_oe_n <= 1'b1;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (!master)
        begin
            scl_cnt <= 9'h000;
            scl_oe_n <= 1'b1;
        end
        else if (scl_cnt >= {address_baud_reg, 1'b1})
        begin
            scl_cnt <= 9'h000;
            scl_oe_n <= ~scl_oe_n; // R01
        end
        else
        begin
            scl_cnt <= scl_cnt + 9'h001;
        end
    end

    // Threshold select forced off on the dedicated pins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ded_sy <= 2'h0;
            thr_sy <= 2'h0;
            pin_threshold_sel <= 1'b0;
        end
        else
        begin
            ded_sy <= {ded_sy[0], dedicated_pins};
            thr_sy <= {thr_sy[0], input_threshold_select};
            pin_threshold_sel <= ded_sy[1] ? 1'b0 : thr_sy[1]; // R07
        end
    end

    // Link domain: pin sampling and static config crossing
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    iab_cfg_t cfg_m;
    iab_cfg_t cfg_l;
    iab_lstate_t lst;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic byte_done;
    logic m7;
    logic mhi;
    logic mlo;

    always_ff @(posedge clk_link or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            cfg_m <= '0;
            cfg_l <= '0;
        end
        else
        begin
            scl_sy <= {scl_sy[0], scl_i};
            sda_sy <= {sda_sy[0], sda_i};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
            cfg_m <= {port_control_one_reg[`IAB_CON1_EN],
                port_control_one_reg[3:0], address_baud_reg,
                address_mask_reg};
            cfg_l <= cfg_m;
        end
    end

    // Masked address compares
    assign rx_byte = {shreg[6:0], sda_sy[1]};
    assign byte_done = scl_sy[1] & ~scl_d && bit_cnt == 4'h7
        && lst != L_IDLE;
    assign m7 = ((rx_byte[7:1] ^ cfg_l.add[7:1])
        & cfg_l.msk[7:1]) == 7'h00; // R05 R09
    assign mhi = rx_byte[7:3] == `IAB_HI_PATTERN // R02
        && ((rx_byte[2:1] ^ cfg_l.add[2:1])
        & cfg_l.msk[2:1]) == 2'h0; // R03 R09
    assign mlo = ((rx_byte ^ cfg_l.add) & cfg_l.msk) == 8'h00; // R04

    // Byte framing and address state machine
    always_ff @(posedge clk_link or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lst <= L_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ev_byte <= 8'h00;
            ev_kind <= EV_A7;
            ev_tgl <= 1'b0;
        end
        else if (scl_sy[1] && scl_d && sda_d && !sda_sy[1])
        begin
            lst <= L_ADDR;
            bit_cnt <= 4'h0;
        end
        else if (scl_sy[1] && scl_d && !sda_d && sda_sy[1])
        begin
            lst <= L_IDLE;
        end
        else if (scl_sy[1] && !scl_d && lst != L_IDLE)
        begin
            // Ninth clock is the acknowledge slot, not shifted
            bit_cnt <= bit_cnt == 4'h8 ? 4'h0 : bit_cnt + 4'h1;
            if (bit_cnt != 4'h8)
            begin
                shreg <= rx_byte;
            end
            if (byte_done)
            begin
                ev_byte <= rx_byte;
                case (lst)
                    L_ADDR:
                    begin
                        if (cfg_l.en && cfg_l.mode[2:0] == `IAB_MODE_SLV7
                            && m7)
                        begin
                            lst <= L_DATA;
                            ev_kind <= EV_A7;
                            ev_tgl <= ~ev_tgl;
                        end
                        else if (cfg_l.en
                            && cfg_l.mode[2:0] == `IAB_MODE_SLV10 && mhi)
                        begin
                            lst <= L_ADDR2;
                            ev_kind <= EV_HI;
                            ev_tgl <= ~ev_tgl;
                        end
                        else
                        begin
                            lst <= L_SKIP;
                        end
                    end
                    L_ADDR2:
                    begin
                        lst <= mlo ? L_DATA : L_SKIP;
                        ev_kind <= EV_LO;
                        ev_tgl <= mlo ? ~ev_tgl : ev_tgl;
                    end
                    L_DATA:
                    begin
                        ev_kind <= EV_DATA;
                        ev_tgl <= ~ev_tgl;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Helper for the SCL period check
    logic [9:0] gap;
    logic gap_ok;
    logic scl_prev;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap <= 10'h000;
            gap_ok <= 1'b0;
            scl_prev <= 1'b1;
        end
        else
        begin
            scl_prev <= scl_oe_n;
            gap <= scl_oe_n != scl_prev ? 10'h001 : gap + 10'h001;
            if (!master || wr_add)
            begin
                gap_ok <= 1'b0;
            end
            else if (scl_oe_n != scl_prev)
            begin
                gap_ok <= 1'b1;
            end
        end
    end

    chk_scl_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scl_oe_n != scl_prev && gap_ok && master && !wr_add
        |-> gap == {1'b0, address_baud_reg, 1'b0} + 10'h002) // R01
        else $error("SCL half period wrong");
    chk_hi_pattern: assert property (@(posedge clk_link) disable iff (!rst_n)
        byte_done && lst == L_ADDR ##1 lst == L_ADDR2
        |-> $past(rx_byte[7:3]) == `IAB_HI_PATTERN) // R02
        else $error("upper byte accepted without 11110");
    chk_hi_bits: assert property (@(posedge clk_link) disable iff (!rst_n)
        lst == L_ADDR ##1 lst == L_ADDR2
        |-> ((ev_byte[2:1] ^ cfg_l.add[2:1]) & cfg_l.msk[2:1]) == 2'h0) // R03
        else $error("upper byte bits 2..1 mismatch");
    chk_lo_match: assert property (@(posedge clk_link) disable iff (!rst_n)
        byte_done && lst == L_ADDR2 && mlo |=> lst == L_DATA
        && ev_byte == $past(rx_byte)) // R04
        else $error("lower byte match lost");
    chk_seven_bit: assert property (@(posedge clk_link) disable iff (!rst_n)
        lst == L_ADDR ##1 lst == L_DATA
        |-> ((ev_byte[7:1] ^ cfg_l.add[7:1]) & cfg_l.msk[7:1]) == 7'h00) // R05
        else $error("7-bit address accepted on mismatch");
    chk_mask_match: assert property (@(posedge clk_link) disable iff (!rst_n)
        byte_done && lst == L_ADDR && cfg_l.en
        && cfg_l.mode[2:0] == `IAB_MODE_SLV7 && m7
        |=> lst == L_DATA ##0 ev_tgl != $past(ev_tgl)) // R09
        else $error("masked 7-bit address not matched");
    chk_buf_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_buf |=> serial_buffer_reg == $past(hwdata[7:0])) // R06
        else $error("buffer write lost");
    chk_thr_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dedicated_pins [*4] |-> !pin_threshold_sel) // R07
        else $error("threshold select not disregarded");
endmodule // iab_top

// file: iab_link_node.sv
// Far-side bus node model: drives frames on the link as a master
`timescale 1ns/1ps
module iab_link_node (
    input wire logic clk_link,
    output logic scl,
    output logic sda
);
    // Both lines released (pulled up) outside frames
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Two link cycles per level so the synchroniser sees each one
    task automatic step();
        repeat (2) @(posedge clk_link);
    endtask
    task automatic start_cond();
        sda <= 1'b0;
        step();
        scl <= 1'b0;
        step();
    endtask
    task automatic stop_cond();
        sda <= 1'b0;
        step();
        scl <= 1'b1;
        step();
        sda <= 1'b1;
        step();
    endtask
    // MSB first, ninth clock with SDA released (no ACK expected)
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= -1; i--)
        begin
            sda <= (i < 0) ? 1'b1 : b[i];
            step();
            scl <= 1'b1;
            step();
            scl <= 1'b0;
            step();
        end
    endtask
endmodule // iab_link_node

// file: iab_top_bench.sv
// Self-checking testbench of the address/baud and buffer register block
`timescale 1ns/1ps
module iab_top_bench;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, dedicated_pins = 1'b0;
    logic input_threshold_select = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic pin_threshold_sel, node_scl, node_sda, scl_w, sda_w;
    int n_errors = 0, total_checks = 0, cyc = 0;
    realtime t0;
    always #2 clk_sys = ~clk_sys;
    initial
    begin
        #7;
        forever #80 clk_link = ~clk_link;
    end
    // Open-drain wires: anyone pulling low wins
    assign scl_w = node_scl & (scl_oe_n ? 1'b1 : scl_o);
    assign sda_w = node_sda & (sda_oe_n ? 1'b1 : sda_o);
    assign hready = hreadyout;
    iab_top DUT (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata(rdat),
        .clk_link, .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o,
        .sda_oe_n, .dedicated_pins, .input_threshold_select,
        .pin_threshold_sel);
    iab_link_node node (.clk_link, .scl(node_scl), .sda(node_sda));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ceiling well above the ~26k cycles the frames need
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single AHB-Lite word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = rdat;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check(r, e);
    endtask
    // Reset long enough for both clock domains
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        repeat (2) @(posedge clk_link);
        @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] b);
        node.start_cond();
        node.send_byte(a);
        node.send_byte(b);
        node.stop_cond();
        repeat (8) @(posedge clk_sys);
    endtask
    logic [7:0] offs [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    initial
    begin
        do_reset();
        for (int i = 0; i < 6; i++)
            rd(offs[i], {24'h0, rstv[i]});
        // Idle SDA released, SCL and SDA outputs low, bus always ready and OKAY
        check({27'h0, hresp, hreadyout, scl_o, sda_o, sda_oe_n}, 32'h9);
        wr(8'h08, 8'hff);
        rd(8'h08, 32'h0);
        wr(8'h1c, 8'h5a);
        rd(8'h1c, 32'h0);
        // Threshold select passes only without the dedicated pins
        input_threshold_select <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({31'h0, pin_threshold_sel}, 32'h1);
        dedicated_pins <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({31'h0, pin_threshold_sel}, 32'h0);
        // Smallest legal divider: period 4 * (3 + 1)
        wr(8'h00, 8'h03);
        wr(8'h0c, 8'h28);
        @(negedge scl_oe_n);
        t0 = $realtime;
        @(posedge scl_oe_n);
        check(32'(int'(($realtime - t0) / 4.0)), 32'd8);
        @(negedge scl_oe_n);
        check(32'(int'(($realtime - t0) / 4.0)), 32'd16);
        wr(8'h0c, 8'h00);
        // Buffer survives a mid-run reset
        wr(8'h04, 8'h5c);
        do_reset();
        rd(8'h04, 32'h5c);
        rd(8'h00, 32'h0);
        // 7-bit slave, address 0x52, R/W bit differs from bit 0
        wr(8'h00, 8'ha4);
        wr(8'h0c, 8'h26);
        frame(8'ha5, 8'h3c);
        rd(8'h08, 32'h21);
        rd(8'h04, 32'h3c);
        rd(8'h08, 32'h20);
        frame(8'hb4, 8'h99);
        rd(8'h04, 32'h3c);
        wr(8'h18, 8'hef);
        frame(8'hb4, 8'h77);
        rd(8'h04, 32'h77);
        // 10-bit slave: wrong fixed pattern is refused
        wr(8'h18, 8'hff);
        wr(8'h00, 8'h06);
        wr(8'h0c, 8'h27);
        frame(8'he7, 8'h11);
        rd(8'h04, 32'h77);
        node.start_cond();
        node.send_byte(8'hf7);
        repeat (8) @(posedge clk_sys);
        // Upper byte loaded: buffer full and update-address set
        rd(8'h08, 32'h03);
        wr(8'h00, 8'h5a);
        rd(8'h08, 32'h01);
        node.send_byte(8'h5a);
        node.send_byte(8'h81);
        node.stop_cond();
        repeat (8) @(posedge clk_sys);
        rd(8'h04, 32'h81);
        wrap_up();
    end
endmodule // iab_top_bench
